// ===== design/dmaau_pkg.sv
package dmaau_pkg;
    // Register byte offsets on APB
    localparam logic [7:0] DMAAU_OFS_SRC = 8'h00;
    localparam logic [7:0] DMAAU_OFS_DST = 8'h04;
    localparam logic [7:0] DMAAU_OFS_OFR = 8'h08;
    localparam logic [7:0] DMAAU_OFS_ACR = 8'h0c;
    localparam logic [7:0] DMAAU_OFS_MDR = 8'h10;
    localparam logic [7:0] DMAAU_OFS_BSZ = 8'h14;
    // address_control_reg field positions
    localparam int DMAAU_ACR_SSEL = 0;
    localparam int DMAAU_ACR_DSEL = 2;
    localparam int DMAAU_ACR_SIZE = 4;
    localparam int DMAAU_ACR_AREA = 6;
    localparam int DMAAU_ACR_SEXT = 8;
    localparam int DMAAU_ACR_DEXT = 16;
    localparam int DMAAU_ACR_SIE  = 24;
    localparam int DMAAU_ACR_DIE  = 25;
    // channel_mode_reg field positions
    localparam int DMAAU_MDR_EN   = 0;
    localparam int DMAAU_MDR_MODE = 1;
    localparam int DMAAU_MDR_ESCAPE_INTERRUPT_ENABLE = 3;
    localparam int DMAAU_MDR_ACT  = 4;
    localparam int DMAAU_MDR_ESCAPE_INTERRUPT_FLAG = 5;
    // block_size_reg halves
    localparam int DMAAU_BSZ_RL   = 16;
    // Step sizes in bytes
    localparam logic [2:0] DMAAU_STEP_B = 3'h1;
    localparam logic [2:0] DMAAU_STEP_W = 3'h2;
    localparam logic [2:0] DMAAU_STEP_L = 3'h4;
    localparam logic [31:0] DMAAU_ALL1 = 32'hffffffff;
    localparam logic [31:0] DMAAU_ZERO = 32'h00000000;
    localparam logic [15:0] DMAAU_CNT_LAST = 16'h0001;
    localparam logic [4:0]  DMAAU_EXT_OFF = 5'h00;

    typedef enum logic [1:0] {
        DMAAU_FIXED  = 2'b00,
        DMAAU_OFFSET = 2'b01,
        DMAAU_INC    = 2'b10,
        DMAAU_DEC    = 2'b11
    } dmaau_upd_t;
    typedef enum logic [1:0] {
        DMAAU_BYTE = 2'b00,
        DMAAU_WORD = 2'b01,
        DMAAU_LONG = 2'b10
    } dmaau_size_t;
    typedef enum logic [1:0] {
        DMAAU_NORMAL = 2'b00,
        DMAAU_REPEAT = 2'b01,
        DMAAU_BLOCK  = 2'b10
    } dmaau_mode_t;
    typedef enum logic [1:0] {
        DMAAU_AREA_NONE = 2'b00,
        DMAAU_AREA_SRC  = 2'b01,
        DMAAU_AREA_DST  = 2'b10
    } dmaau_area_t;
    typedef enum logic [1:0] {
        DMAAU_IDLE  = 2'b00,
        DMAAU_READ  = 2'b01,
        DMAAU_WRITE = 2'b10
    } dmaau_st_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } dmaau_apb_in_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } dmaau_apb_out_t;
    typedef struct packed {
        logic        req;
        logic        write;
        dmaau_size_t size;
        logic [31:0] addr;
    } dmaau_bus_t;

    typedef struct packed {
        logic [31:0] src;
        logic [31:0] dst;
        logic [31:0] ofs;
        logic [31:0] acr;
        logic        en;
        logic        escape_interrupt_enable;
        logic        escape_interrupt_flag;
        dmaau_mode_t mode;
        logic [15:0] bsz_rl;
        logic [15:0] bsz_cnt;
        logic [31:0] src_start;
        logic [31:0] dst_start;
        logic [31:0] ustart;
        logic [2:0]  rem;
        logic        ovf_pend;
        dmaau_st_t   st;
    } dmaau_state_t;
endpackage

// ===== design/dmaau_side.sv
`timescale 1ns/1ps
// Next-address calculator for one side (source or destination)
module dmaau_side
    import dmaau_pkg::*;
(
    input  wire logic [31:0]        cur,
    input  wire logic [31:0]        ustart,
    input  wire logic [2:0]         rem,
    input  wire dmaau_pkg::dmaau_upd_t  sel,
    input  wire dmaau_pkg::dmaau_size_t size,
    input  wire logic [31:0]        offset,
    input  wire logic [4:0]         ext,
    output dmaau_pkg::dmaau_size_t  piece,
    output logic [2:0]              piece_bytes,
    output logic [31:0]             unit_next,
    output logic                    area_ovf
);
    import dmaau_pkg::*;
    logic [31:0] step;   // Unit step
    logic [31:0] upd;    // Unrestricted next address
    logic [31:0] mask;   // Bits allowed to change

    // Unit step and raw update; sums simply wrap
    always_comb begin
        case (size)
            DMAAU_WORD: step = {29'h0, DMAAU_STEP_W};
            DMAAU_LONG: step = {29'h0, DMAAU_STEP_L};
            default:    step = {29'h0, DMAAU_STEP_B};
        endcase
        case (sel)
            DMAAU_OFFSET: upd = ustart + offset;
            DMAAU_INC:    upd = ustart + step;
            DMAAU_DEC:    upd = ustart - step;
            default:      upd = ustart;
        endcase
    end

    // Extended area: only low ext bits move, upper bits frozen
    always_comb begin
        if (ext == DMAAU_EXT_OFF) begin
            mask = DMAAU_ALL1;
        end else begin
            mask = ~(DMAAU_ALL1 << ext);
        end
        unit_next = (ustart & ~mask) | (upd & mask);
        area_ovf  = (ext != DMAAU_EXT_OFF) &&
                    (((upd ^ ustart) & ~mask) != DMAAU_ZERO);
    end

    // Piece size: largest naturally aligned part still owed
    always_comb begin
        if (cur[0] || rem == DMAAU_STEP_B) begin
            piece = DMAAU_BYTE;
            piece_bytes = DMAAU_STEP_B;
        end else if (cur[1] || rem < DMAAU_STEP_L) begin
            piece = DMAAU_WORD;
            piece_bytes = DMAAU_STEP_W;
        end else begin
            piece = DMAAU_LONG;
            piece_bytes = DMAAU_STEP_L;
        end
    end
endmodule // dmaau_side

// ===== design/dmaau_top.sv
`timescale 1ns/1ps
// Address update unit of one DMA channel with its APB registers
module dmaau_top
    import dmaau_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    ce,
    input  wire dmaau_pkg::dmaau_apb_in_t apb_i,
    output dmaau_pkg::dmaau_apb_out_t    apb_o,
    input  wire logic                    xfer_req,
    input  wire logic                    bus_ack,
    output dmaau_pkg::dmaau_bus_t        bus_o,
    output logic                         esc_irq
);
    import dmaau_pkg::*;

    dmaau_state_t r_ff;         // All state of the unit
    dmaau_state_t nxt_r;        // Next value of it
    dmaau_size_t  s_piece;      // Source piece size
    dmaau_size_t  d_piece;      // Destination piece size
    logic [2:0]   s_pbytes;     // Source piece in bytes
    logic [2:0]   d_pbytes;     // Destination piece in bytes
    logic [31:0]  s_next;       // Source after the unit
    logic [31:0]  d_next;       // Destination after the unit
    logic         s_ovf;        // Source area overflow
    logic         d_ovf;        // Destination area overflow
    logic [2:0]   unit_bytes;   // Bytes in one unit
    logic         wr_acc;       // APB write access phase
    logic         rd_acc;       // APB read access phase
    logic         s_last;       // Final source piece acked
    logic         d_last;       // Final destination piece acked
    logic         blk_end;      // Block or repeat size reached
    logic         stop_evt;     // Stop the channel now
    dmaau_size_t  cfg_size;     // Access size field
    dmaau_area_t  cfg_area;     // Side holding the block area

    assign cfg_size = dmaau_size_t'(r_ff.acr[DMAAU_ACR_SIZE +: 2]);
    assign cfg_area = dmaau_area_t'(r_ff.acr[DMAAU_ACR_AREA +: 2]);

    // Source side calculator
    dmaau_side u_src (
        .cur         (r_ff.src),
        .ustart      (r_ff.ustart),
        .rem         (r_ff.rem),
        .sel         (dmaau_upd_t'(r_ff.acr[DMAAU_ACR_SSEL +: 2])),
        .size        (cfg_size),
        .offset      (r_ff.ofs),
        .ext         (r_ff.acr[DMAAU_ACR_SEXT +: 5]),
        .piece       (s_piece),
        .piece_bytes (s_pbytes),
        .unit_next   (s_next),
        .area_ovf    (s_ovf)
    );

    // Destination side calculator
    dmaau_side u_dst (
        .cur         (r_ff.dst),
        .ustart      (r_ff.ustart),
        .rem         (r_ff.rem),
        .sel         (dmaau_upd_t'(r_ff.acr[DMAAU_ACR_DSEL +: 2])),
        .size        (cfg_size),
        .offset      (r_ff.ofs),
        .ext         (r_ff.acr[DMAAU_ACR_DEXT +: 5]),
        .piece       (d_piece),
        .piece_bytes (d_pbytes),
        .unit_next   (d_next),
        .area_ovf    (d_ovf)
    );

    // Unit length in bytes; reserved size code acts as byte
    always_comb begin
        case (cfg_size)
            DMAAU_WORD: unit_bytes = DMAAU_STEP_W;
            DMAAU_LONG: unit_bytes = DMAAU_STEP_L;
            default:    unit_bytes = DMAAU_STEP_B;
        endcase
    end

    // Transfer and APB qualifiers
    assign wr_acc  = apb_i.psel & apb_i.penable & apb_i.pwrite;
    assign rd_acc  = apb_i.psel & apb_i.penable & ~apb_i.pwrite;
    assign s_last  = (r_ff.st == DMAAU_READ) & bus_ack &
                     (r_ff.rem == s_pbytes);
    assign d_last  = (r_ff.st == DMAAU_WRITE) & bus_ack &
                     (r_ff.rem == d_pbytes);
    assign blk_end = d_last & (r_ff.mode != DMAAU_NORMAL) &
                     (r_ff.bsz_cnt == DMAAU_CNT_LAST);
    // Stop at the end of the unit that raised the condition; a
    // destination overflow is only known at that unit's last piece,
    // so waiting for the pending bit would stop one unit too late
    assign stop_evt = (blk_end & (r_ff.mode == DMAAU_REPEAT)) |
                      (d_last & r_ff.ovf_pend) |
                      (d_last & d_ovf & r_ff.acr[DMAAU_ACR_DIE]);

    // Next-state logic: engine first, CPU writes override it
    always_comb begin
        nxt_r = r_ff;
        case (r_ff.st)
            DMAAU_IDLE: begin
                // Leaves enable alone: resumes exactly where it was
                if (r_ff.en && xfer_req) begin
                    nxt_r.st     = DMAAU_READ;
                    nxt_r.ustart = r_ff.src;
                    nxt_r.rem    = unit_bytes;
                end
            end
            DMAAU_READ: begin
                if (s_last) begin
                    // Whole unit read: unit start updated per source select
                    nxt_r.src    = s_next;
                    nxt_r.ustart = r_ff.dst;
                    nxt_r.rem    = unit_bytes;
                    nxt_r.st     = DMAAU_WRITE;
                    nxt_r.ovf_pend = s_ovf & r_ff.acr[DMAAU_ACR_SIE];
                end else if (bus_ack) begin
                    // Intermediate piece advances by its own size
                    nxt_r.src = r_ff.src + {29'h0, s_pbytes};
                    nxt_r.rem = r_ff.rem - s_pbytes;
                end
            end
            DMAAU_WRITE: begin
                if (d_last) begin
                    nxt_r.dst = d_next;
                    nxt_r.st  = DMAAU_IDLE;
                    if (d_ovf && r_ff.acr[DMAAU_ACR_DIE]) begin
                        nxt_r.ovf_pend = 1'b1;
                    end
                    if (r_ff.mode != DMAAU_NORMAL) begin
                        nxt_r.bsz_cnt = r_ff.bsz_cnt - DMAAU_CNT_LAST;
                    end
                    if (blk_end) begin
                        // Counter does not step from one to zero: reload instead
                        nxt_r.bsz_cnt = r_ff.bsz_rl;
                        if (cfg_area == DMAAU_AREA_SRC) begin
                            nxt_r.src = r_ff.src_start;
                        end
                        if (cfg_area == DMAAU_AREA_DST) begin
                            nxt_r.dst = r_ff.dst_start;
                        end
                    end
                end else if (bus_ack) begin
                    nxt_r.dst = r_ff.dst + {29'h0, d_pbytes};
                    nxt_r.rem = r_ff.rem - d_pbytes;
                end
            end
            default: begin
                nxt_r.st = DMAAU_IDLE;
            end
        endcase
        if (d_last && stop_evt) begin
            nxt_r.ovf_pend = 1'b0;
        end
        // CPU writes take priority over the address update
        if (wr_acc) begin
            case (apb_i.paddr)
                DMAAU_OFS_SRC: begin
                    // New source also becomes the area start
                    nxt_r.src       = apb_i.pwdata;
                    nxt_r.src_start = apb_i.pwdata;
                end
                DMAAU_OFS_DST: begin
                    nxt_r.dst       = apb_i.pwdata;
                    nxt_r.dst_start = apb_i.pwdata;
                end
                DMAAU_OFS_OFR: nxt_r.ofs = apb_i.pwdata;
                DMAAU_OFS_ACR: nxt_r.acr = apb_i.pwdata;
                DMAAU_OFS_MDR: begin
                    nxt_r.en   = apb_i.pwdata[DMAAU_MDR_EN];
                    nxt_r.mode = dmaau_mode_t'(
                                 apb_i.pwdata[DMAAU_MDR_MODE +: 2]);
                    nxt_r.escape_interrupt_enable = apb_i.pwdata[DMAAU_MDR_ESCAPE_INTERRUPT_ENABLE];
                    // Resuming by setting enable clears the escape flag
                    if (!r_ff.en && apb_i.pwdata[DMAAU_MDR_EN]) begin
                        nxt_r.escape_interrupt_flag = 1'b0;
                    end
                end
                DMAAU_OFS_BSZ: begin
                    nxt_r.bsz_rl  = apb_i.pwdata[DMAAU_BSZ_RL +: 16];
                    nxt_r.bsz_cnt = apb_i.pwdata[DMAAU_BSZ_RL-1:0];
                end
                default: begin
                    // Unmapped: ignored, flagged on pslverr
                end
            endcase
        end
        // Hardware stop wins over a same-cycle software clear
        if (stop_evt) begin
            nxt_r.en   = 1'b0;
            nxt_r.escape_interrupt_flag = 1'b1;
        end
    end

    // State register; ce low freezes everything, but sys_rst still clears it
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r_ff <= '0;
        end else if (ce) begin
            r_ff <= nxt_r;
        end
    end

    // Bus request: the live register goes out before it updates
    always_comb begin
        bus_o.req   = (r_ff.st != DMAAU_IDLE);
        bus_o.write = (r_ff.st == DMAAU_WRITE);
        if (r_ff.st == DMAAU_WRITE) begin
            bus_o.size = d_piece;
            bus_o.addr = r_ff.dst;
        end else begin
            bus_o.size = s_piece;
            bus_o.addr = r_ff.src;
        end
    end

    assign esc_irq = r_ff.escape_interrupt_flag & r_ff.escape_interrupt_enable;

    // APB read mux; zero wait states, error on unmapped offsets
    always_comb begin
        apb_o.pready  = 1'b1;
        apb_o.pslverr = 1'b0;
        apb_o.prdata  = DMAAU_ZERO;
        case (apb_i.paddr)
            DMAAU_OFS_SRC: apb_o.prdata = r_ff.src;
            DMAAU_OFS_DST: apb_o.prdata = r_ff.dst;
            DMAAU_OFS_OFR: apb_o.prdata = r_ff.ofs;
            DMAAU_OFS_ACR: apb_o.prdata = r_ff.acr;
            DMAAU_OFS_MDR: begin
                apb_o.prdata[DMAAU_MDR_EN]        = r_ff.en;
                apb_o.prdata[DMAAU_MDR_MODE +: 2] = r_ff.mode;
                apb_o.prdata[DMAAU_MDR_ESCAPE_INTERRUPT_ENABLE]      = r_ff.escape_interrupt_enable;
                apb_o.prdata[DMAAU_MDR_ACT] = (r_ff.st != DMAAU_IDLE);
                apb_o.prdata[DMAAU_MDR_ESCAPE_INTERRUPT_FLAG]      = r_ff.escape_interrupt_flag;
            end
            DMAAU_OFS_BSZ: apb_o.prdata = {r_ff.bsz_rl, r_ff.bsz_cnt};
            default: apb_o.pslverr = (wr_acc | rd_acc);
        endcase
    end

    // Checks on the address arithmetic and the stop sequence
    chk_fixed_src: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (ce && s_last && !wr_acc &&
         r_ff.acr[DMAAU_ACR_SSEL +: 2] == DMAAU_FIXED &&
         r_ff.acr[DMAAU_ACR_SEXT +: 5] == DMAAU_EXT_OFF)
        |=> r_ff.src == $past(r_ff.ustart))
        else $error("fixed source address moved");

    chk_inc_long: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (ce && s_last && !wr_acc && cfg_size == DMAAU_LONG &&
         r_ff.acr[DMAAU_ACR_SSEL +: 2] == DMAAU_INC &&
         r_ff.acr[DMAAU_ACR_SEXT +: 5] == DMAAU_EXT_OFF)
        |=> r_ff.src == $past(r_ff.ustart) + {29'h0, DMAAU_STEP_L})
        else $error("longword increment not by four");

    chk_offset_dst: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (ce && d_last && !wr_acc && r_ff.mode == DMAAU_NORMAL &&
         r_ff.acr[DMAAU_ACR_DSEL +: 2] == DMAAU_OFFSET &&
         r_ff.acr[DMAAU_ACR_DEXT +: 5] == DMAAU_EXT_OFF)
        |=> r_ff.dst == $past(r_ff.ustart + r_ff.ofs))
        else $error("destination offset not added");

    // First piece of a unit goes out at the register's old value
    chk_bus_addr: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (ce && r_ff.st == DMAAU_IDLE && r_ff.en && xfer_req && !wr_acc)
        |=> (bus_o.addr == $past(r_ff.src) && bus_o.req && !bus_o.write))
        else $error("read address is not the source register");

    chk_split_odd: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (bus_o.req && bus_o.addr[0]) |-> bus_o.size == DMAAU_BYTE)
        else $error("odd address not split to bytes");

    chk_piece_adv: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (ce && r_ff.st == DMAAU_READ && bus_ack && !s_last && !wr_acc)
        |=> r_ff.src == $past(r_ff.src) + {29'h0, $past(s_pbytes)})
        else $error("split piece did not advance");

    chk_rpt_stop: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (ce && blk_end && r_ff.mode == DMAAU_REPEAT)
        |=> (!r_ff.en && r_ff.escape_interrupt_flag && r_ff.st == DMAAU_IDLE))
        else $error("repeat end did not stop the channel");

    chk_ext_upper: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (ce && s_last && !wr_acc &&
         r_ff.acr[DMAAU_ACR_SEXT +: 5] != DMAAU_EXT_OFF)
        |=> ((r_ff.src ^ $past(r_ff.ustart)) >>
             $past(r_ff.acr[DMAAU_ACR_SEXT +: 5])) == DMAAU_ZERO)
        else $error("upper bits changed inside extended area");

    chk_src_reload: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (ce && blk_end && !wr_acc && cfg_area == DMAAU_AREA_SRC)
        |=> r_ff.src == $past(r_ff.src_start))
        else $error("source not reloaded at area end");

    chk_dst_reload: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        (ce && blk_end && !wr_acc && cfg_area == DMAAU_AREA_DST)
        |=> r_ff.dst == $past(r_ff.dst_start))
        else $error("destination not reloaded at area end");
endmodule // dmaau_top

// ===== tb/dma_address_update_unit_tb.sv
`timescale 1ns/1ps
// Self-checking bench: APB master, reference model, bus piece checks
module dma_address_update_unit_tb;
    import dmaau_pkg::*;
    logic           ref_clk = 1'b0;  // 20 MHz
    logic           sys_rst = 1'b1;
    logic           xfer_req = 1'b0;
    logic           ce = 1'b1;       // Clock enable of the unit
    logic           bus_ack;
    logic [1:0]     lat = 2'h0;      // Partner answer delay
    dmaau_apb_in_t  apb = '0;
    dmaau_apb_out_t apb_o;
    dmaau_bus_t     bus_o;
    logic           esc_irq;
    logic [34:0]    exp_q[$];        // Expected {write,size,addr}
    logic [31:0]    lfsr = 32'h41;   // Seed 65
    logic [31:0]    rdat;
    logic           rerr;
    int             mismatches = 0;
    int             check_count = 0;

    always #25 ref_clk = ~ref_clk;

    dmaau_top i_dmaau_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce),
        .apb_i(apb), .apb_o(apb_o), .xfer_req(xfer_req), .bus_ack(bus_ack),
        .bus_o(bus_o), .esc_irq(esc_irq));
    dmaau_bus_model i_dmaau_bus_model (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .req(bus_o.req), .lat(lat), .ack(bus_ack));

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_bus(input logic [34:0] g, input logic [34:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    function automatic logic [31:0] rnd();
        repeat (32) lfsr = {lfsr[30:0], lfsr[31]^lfsr[21]^lfsr[1]^lfsr[0]};
        return lfsr;
    endfunction

    // Reference next address; wraps at 32 bits like the register
    function automatic logic [31:0] nxt(input logic [31:0] a,
        input logic [1:0] sel, input logic [1:0] sz, input logic [31:0] o);
        logic [31:0] st;
        st = (sz == 2'b10) ? 32'h4 : (sz == 2'b01) ? 32'h2 : 32'h1;
        case (sel)
            2'b00: return a;
            2'b01: return a + o;
            2'b10: return a + st;
            default: return a - st;
        endcase
    endfunction

    // Split a unit into ascending aligned pieces
    task automatic add_pcs(input logic w, input logic [31:0] a,
        input logic [1:0] sz);
        int n;
        int p;
        n = (sz == 2'b10) ? 4 : (sz == 2'b01) ? 2 : 1;
        while (n > 0) begin
            p = (a[0] || n == 1) ? 1 : ((a[1] || n < 4) ? 2 : 4);
            exp_q.push_back({w, (p == 4) ? 2'b10 : 2'(p - 1), a});
            a = a + 32'(p);
            n = n - p;
        end
    endtask

    // APB transfer; request held until pready is seen high
    task automatic apb_xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        apb.psel <= 1'b1;
        apb.pwrite <= w;
        apb.paddr <= a;
        apb.pwdata <= d;
        @(posedge ref_clk);
        apb.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (apb_o.pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            mismatches++;
            complete_run;
        end
        rdat = apb_o.prdata;
        rerr = apb_o.pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask

    // Every accepted piece must match the model queue
    always @(posedge ref_clk) begin
        if (bus_o.req === 1'b1 && bus_ack === 1'b1)
            chk_bus({bus_o.write, bus_o.size, bus_o.addr},
                exp_q.size() ? exp_q.pop_front() : 'x);
    end

    task automatic run_unit(input logic [31:0] s, d, o, acr, input bit rpt);
        logic [31:0] se;
        logic [31:0] de;
        logic [31:0] ms;
        logic [31:0] md;
        int k;
        se = nxt(s, acr[1:0], acr[5:4], o);
        de = nxt(d, acr[3:2], acr[5:4], o);
        // Extended area: only the low bits may move
        ms = ~(32'hffffffff << acr[12:8]);
        md = ~(32'hffffffff << acr[20:16]);
        if (acr[12:8] != 5'h0) se = (s & ~ms) | (se & ms);
        if (acr[20:16] != 5'h0) de = (d & ~md) | (de & md);
        if (rpt && acr[7:6] == 2'b01) se = s;
        if (rpt && acr[7:6] == 2'b10) de = d;
        apb_xfer(1'b1, DMAAU_OFS_SRC, s);
        apb_xfer(1'b1, DMAAU_OFS_DST, d);
        apb_xfer(1'b1, DMAAU_OFS_OFR, o);
        apb_xfer(1'b1, DMAAU_OFS_ACR, acr);
        apb_xfer(1'b1, DMAAU_OFS_BSZ, rpt ? 32'h00010001 : 32'h0);
        apb_xfer(1'b1, DMAAU_OFS_MDR, rpt ? 32'hb : 32'h1);
        add_pcs(1'b0, s, acr[5:4]);
        add_pcs(1'b1, d, acr[5:4]);
        @(posedge ref_clk);
        xfer_req <= 1'b1;
        @(posedge ref_clk);
        xfer_req <= 1'b0;
        // Sample on the falling edge, clear of the piece checker
        for (k = 0; k < 400; k++) begin
            @(negedge ref_clk);
            if (exp_q.size() == 0 && bus_o.req === 1'b0) break;
        end
        if (k >= 400) begin
            mismatches++;
            complete_run;
        end
        apb_xfer(1'b0, DMAAU_OFS_SRC, 32'h0);
        chk_reg(rdat, se);
        apb_xfer(1'b0, DMAAU_OFS_DST, 32'h0);
        chk_reg(rdat, de);
        if (rpt || acr[DMAAU_ACR_SIE]) begin
            apb_xfer(1'b0, DMAAU_OFS_MDR, 32'h0);
            chk_reg(rdat & 32'h31, 32'h20);
            chk_reg({31'h0, esc_irq}, {31'h0, rpt});
        end
        // Channel stopped before its addresses are touched again
        apb_xfer(1'b1, DMAAU_OFS_MDR, 32'h0);
    endtask

    initial begin
        logic [31:0] r;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // Clock enable low: the write must leave no trace
        ce <= 1'b0;
        apb_xfer(1'b1, DMAAU_OFS_SRC, 32'h55);
        ce <= 1'b1;
        apb_xfer(1'b0, DMAAU_OFS_SRC, 32'h0);
        chk_reg(rdat, 32'h0);
        apb_xfer(1'b0, 8'h18, 32'h0);
        chk_reg({rdat[30:0], rerr}, 32'h1);
        // All select pairs and sizes, random misaligned addresses
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            lat <= r[31:30];
            run_unit(rnd(), rnd(), rnd(),
                {26'h0, 2'(i % 3), i[3:2], i[1:0]}, 1'b0);
        end
        run_unit(32'hfffffffe, 32'h1, 32'h0, 32'h2a, 1'b0);
        run_unit(32'h10fc, 32'h50c, 32'h0, 32'h0104082a, 1'b0);
        run_unit(32'h1000, 32'h2003, ~32'h10 + 1, 32'h15, 1'b0);
        run_unit(32'h3003, 32'h400, 32'h10, 32'h69, 1'b1);
        run_unit(32'h3000, 32'h402, 32'h10, 32'ha9, 1'b1);
        complete_run;
    end
endmodule // dma_address_update_unit_tb

// ===== tb/dmaau_bus_model.sv
`timescale 1ns/1ps
// Bus controller stand-in: accepts each pending piece lat+1 cycles after it appears
module dmaau_bus_model
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       req,
    input  wire logic [1:0] lat,
    output logic            ack
);
    logic [1:0] wait_ff; // Cycles already waited for this piece

    // One-cycle accept pulse; the wait restarts for every piece
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !req || ack) begin
            wait_ff <= 2'h0;
            ack     <= 1'b0;
        end else if (wait_ff >= lat) begin
            ack <= 1'b1;
        end else begin
            wait_ff <= wait_ff + 2'h1;
        end
    end
endmodule // dmaau_bus_model
